// *** common/alarm_pkg.sv ***
// package: offsets, field layout, reset values and match codes of the alarm block
package alarm_pkg;
  localparam int unsigned ADDR_W = 8;
  // register offsets
  localparam logic [7:0] OFS_A0_SEC = 8'h0c;
  localparam logic [7:0] OFS_A0_MIN = 8'h0d;
  localparam logic [7:0] OFS_A0_HOUR = 8'h0e;
  localparam logic [7:0] OFS_A0_WEEKDAY_VALUE = 8'h0f;
  localparam logic [7:0] OFS_A0_DATE = 8'h10;
  localparam logic [7:0] OFS_A0_MONTH = 8'h11;
  localparam logic [7:0] OFS_A1_HSEC = 8'h12;
  localparam logic [7:0] OFS_A1_SEC = 8'h13;
  localparam logic [7:0] OFS_A1_MIN = 8'h14;
  localparam logic [7:0] OFS_A1_HOUR = 8'h15;
  localparam logic [7:0] OFS_A1_WEEKDAY_VALUE = 8'h16;
  localparam logic [7:0] OFS_A1_DATE = 8'h17;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  // writable-bit masks; other bits read as zero, except hour bit 6, which reads the format mirror
  localparam logic [7:0] MASK_SEC = 8'h7f;
  localparam logic [7:0] MASK_MIN = 8'h7f;
  localparam logic [7:0] MASK_HOUR = 8'h3f;
  localparam logic [7:0] MASK_WEEKDAY_VALUE = 8'h7f;
  localparam logic [7:0] MASK_DATE = 8'h3f;
  localparam logic [7:0] MASK_MONTH = 8'h1f;
  localparam logic [7:0] MASK_CONTROL = 8'h7f;
  // field positions
  localparam int unsigned FLAG_BIT = 3;
  localparam int unsigned FORMAT_BIT = 6;
  localparam int unsigned PM_BIT = 5;
  localparam int unsigned SEL_LSB = 4;
  localparam int unsigned EN0_BIT = 4;
  localparam int unsigned EN1_BIT = 5;
  localparam int unsigned SQW_BIT = 6;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONE = 8'h01;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  // match-select codes
  typedef enum logic [2:0] {
    SEL_SEC = 3'h0,
    SEL_MIN = 3'h1,
    SEL_HOUR = 3'h2,
    SEL_WEEKDAY_VALUE = 3'h3,
    SEL_DATE = 3'h4,
    SEL_HSEC = 3'h5,
    SEL_RSVD = 3'h6,
    SEL_FULL = 3'h7
  } match_sel_t;
  // current time from the timekeeping counters
  typedef struct packed {
    logic [7:0] hsec;
    logic [6:0] sec;
    logic [6:0] min;
    logic [6:0] hour;
    logic [2:0] weekday_value;
    logic [5:0] date;
    logic [4:0] month;
  } time_now_t;
  // register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage : alarm_pkg

// *** hw/dual_calendar_alarm_match.sv ***
// dual calendar alarm match units with register file and shared alarm pin
// Notes on behaviour
// - alarm 1 hundredths held as two bcd digits
// - hundredths compare only on alarm 1
// - seconds match seven bits, top reads zero
// - minutes match seven bits, top reads zero
// - hour format bit read-only, mirrors timekeeping
// - twelve-hour: bit 5 afternoon, bit 4 tens
// - twenty-four-hour: bits 5-4 tens digit
// - three-bit select chooses the match condition
// - hour compare honours format and afternoon bit
// - month compare only on alarm 0 full
// - match sets sticky flag in weekday bit 3
// - writing zero clears flag, one ignored
// - weekday value 1..7, meaning user defined
// - date match six bits, top two zero
// - alarm 0 month five bits, rest zero
// - alarm matches only while its enable set
// - either flag pulls shared pin low unless the square wave bit is set
`timescale 1ns/1ps
`default_nettype none
module dual_calendar_alarm_match
  import alarm_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // register access from the serial interface
  input wire reg_req_t i_req,
  output logic [7:0] o_rdata,
  // timekeeping counters
  input wire logic i_tick,
  input wire time_now_t i_now,
  input wire logic i_format_12h,
  // shared multifunction pin, open drain
  output logic o_mfp_out,
  output logic o_mfp_oe,
  output logic [7:0] o_control
);
  logic [7:0] a0_sec, a0_min, a0_hour, a0_wk, a0_date, a0_month;
  logic [7:0] a1_hsec, a1_sec, a1_min, a1_hour, a1_wk, a1_date;
  logic [7:0] control;
  logic [7:0] next_rdata;
  logic [7:0] rdata;
  logic flag0, flag1;
  wire logic wr = i_req.wr;
  wire logic [7:0] wd = i_req.wdata;

  // all checks below run on the one timekeeping clock and pause in reset
  default clocking cb_main @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  // plain value registers; write masks keep unimplemented bits at zero
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a0_sec <= RST_ZERO;
      a0_min <= RST_ZERO;
      a0_hour <= RST_ZERO;
      a0_wk <= RST_ONE;
      a0_date <= RST_ONE;
      a0_month <= RST_ONE;
      a1_hsec <= RST_ZERO;
      a1_sec <= RST_ZERO;
      a1_min <= RST_ZERO;
      a1_hour <= RST_ZERO;
      a1_wk <= RST_ONE;
      a1_date <= RST_ONE;
      control <= RST_CONTROL;
    end else if (wr) begin
      unique case (i_req.addr)
        OFS_A0_SEC: a0_sec <= wd & MASK_SEC;
        OFS_A0_MIN: a0_min <= wd & MASK_MIN;
        OFS_A0_HOUR: a0_hour <= wd & MASK_HOUR;
        OFS_A0_WEEKDAY_VALUE: a0_wk <= wd & MASK_WEEKDAY_VALUE;
        OFS_A0_DATE: a0_date <= wd & MASK_DATE;
        OFS_A0_MONTH: a0_month <= wd & MASK_MONTH;
        OFS_A1_HSEC: a1_hsec <= wd;
        OFS_A1_SEC: a1_sec <= wd & MASK_SEC;
        OFS_A1_MIN: a1_min <= wd & MASK_MIN;
        OFS_A1_HOUR: a1_hour <= wd & MASK_HOUR;
        OFS_A1_WEEKDAY_VALUE: a1_wk <= wd & MASK_WEEKDAY_VALUE;
        OFS_A1_DATE: a1_date <= wd & MASK_DATE;
        OFS_CONTROL: control <= wd & MASK_CONTROL;
        default: ;
      endcase
    end
  end

  // unimplemented bits must never pick up a written one, or reads would lie
  a_top_zero: assert property (
    !a0_sec[7] && !a1_min[7] && a0_month[7:5] == 3'h0)
    else $error("unused bit set");
  a_minsec_top: assert property (
    !a1_sec[7] && !a0_min[7])
    else $error("minute or second top bit set");
  a_date_top: assert property (
    a0_date[7:6] == 2'h0 && a1_date[7:6] == 2'h0)
    else $error("date top bits set");
  a_hour_top: assert property (
    a0_hour[7:6] == 2'h0 && a1_hour[7:6] == 2'h0)
    else $error("hour format bit stored");
  a_wk_top: assert property (
    !a0_wk[7] && !a1_wk[7])
    else $error("weekday top bit set");
  a_ctrl_write: assert property (
    wr && i_req.addr == OFS_CONTROL |=> o_control == ($past(wd) & MASK_CONTROL))
    else $error("control write lost");

  // hour compare: the format mirror is bit 6, the stored bits 5..0 include pm
  function automatic logic hour_eq(input logic [7:0] alm, input logic [6:0] now,
                                   input logic fmt12);
    logic eq;
    eq = fmt12 ? (alm[5:0] == now[5:0]) : (alm[5:4] == now[5:4] && alm[3:0] == now[3:0]);
    return eq;
  endfunction : hour_eq

  // per-alarm field matches
  wire logic a0_sec_eq = (a0_sec[6:0] == i_now.sec);
  wire logic a0_min_eq = (a0_min[6:0] == i_now.min);
  wire logic a0_hr_eq = hour_eq(a0_hour, i_now.hour, i_format_12h);
  wire logic a0_wk_eq = (a0_wk[2:0] == i_now.weekday_value);
  wire logic a0_dt_eq = (a0_date[5:0] == i_now.date);
  wire logic a0_mo_eq = (a0_month[4:0] == i_now.month);
  wire logic a1_hs_eq = (a1_hsec == i_now.hsec);
  wire logic a1_sec_eq = (a1_sec[6:0] == i_now.sec);
  wire logic a1_min_eq = (a1_min[6:0] == i_now.min);
  wire logic a1_hr_eq = hour_eq(a1_hour, i_now.hour, i_format_12h);
  wire logic a1_wk_eq = (a1_wk[2:0] == i_now.weekday_value);
  wire logic a1_dt_eq = (a1_date[5:0] == i_now.date);
  wire match_sel_t sel0 = match_sel_t'(a0_wk[SEL_LSB +: 3]);
  wire match_sel_t sel1 = match_sel_t'(a1_wk[SEL_LSB +: 3]);

  // select decode; reserved codes never match
  logic hit0, hit1;
  always_comb begin
    unique case (sel0)
      SEL_SEC: hit0 = a0_sec_eq;
      SEL_MIN: hit0 = a0_min_eq;
      SEL_HOUR: hit0 = a0_hr_eq;
      SEL_WEEKDAY_VALUE: hit0 = a0_wk_eq;
      SEL_DATE: hit0 = a0_dt_eq;
      SEL_HSEC: hit0 = 1'b0;
      SEL_RSVD: hit0 = 1'b0;
      SEL_FULL: hit0 = a0_sec_eq & a0_min_eq & a0_hr_eq & a0_wk_eq & a0_dt_eq & a0_mo_eq;
    endcase
    unique case (sel1)
      SEL_SEC: hit1 = a1_sec_eq;
      SEL_MIN: hit1 = a1_min_eq;
      SEL_HOUR: hit1 = a1_hr_eq;
      SEL_WEEKDAY_VALUE: hit1 = a1_wk_eq;
      SEL_DATE: hit1 = a1_dt_eq;
      SEL_HSEC: hit1 = a1_hs_eq;
      SEL_RSVD: hit1 = 1'b0;
      SEL_FULL: hit1 = a1_sec_eq & a1_min_eq & a1_hr_eq & a1_wk_eq & a1_dt_eq;
    endcase
  end

  // a match counts only on the update tick and while enabled
  wire logic set0 = i_tick & control[EN0_BIT] & hit0;
  wire logic set1 = i_tick & control[EN1_BIT] & hit1;
  wire logic clr0 = wr && i_req.addr == OFS_A0_WEEKDAY_VALUE && !wd[FLAG_BIT];
  wire logic clr1 = wr && i_req.addr == OFS_A1_WEEKDAY_VALUE && !wd[FLAG_BIT];

  // a match is armed only on an update tick of an enabled alarm
  sequence s_armed0;
    i_tick && control[EN0_BIT];
  endsequence
  sequence s_armed1;
    i_tick && control[EN1_BIT];
  endsequence
  a_sec0_match: assert property (
    s_armed0 ##0 (sel0 == SEL_SEC && a0_sec[6:0] == i_now.sec) |=> flag0)
    else $error("alarm 0 seconds match missed");
  a_hour_pm: assert property (
    s_armed0 ##0 (sel0 == SEL_HOUR && i_format_12h && !flag0 &&
    a0_hour[PM_BIT] != i_now.hour[PM_BIT]) |=> !flag0)
    else $error("afternoon bit ignored");
  a_month_full0: assert property (
    s_armed0 ##0 (sel0 == SEL_FULL && !flag0 && a0_month[4:0] != i_now.month) |=> !flag0)
    else $error("alarm 0 month ignored");
  a_full1_nomonth: assert property (
    s_armed1 ##0 (sel1 == SEL_FULL && a1_sec_eq && a1_min_eq && a1_hr_eq && a1_wk_eq &&
    a1_dt_eq) |=> flag1)
    else $error("alarm 1 full match missed");
  a_hsec1_match: assert property (
    s_armed1 ##0 (sel1 == SEL_HSEC && a1_hsec == i_now.hsec) |=> flag1)
    else $error("alarm 1 hundredths missed");
  a_rsvd0_quiet: assert property (
    sel0 == SEL_RSVD && !flag0 |=> !flag0)
    else $error("alarm 0 reserved select matched");
  a_rsvd1_quiet: assert property (
    sel1 == SEL_RSVD && !flag1 |=> !flag1)
    else $error("alarm 1 reserved select matched");

  // sticky flags: set beats a same-cycle clear, written ones are ignored
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag0 <= 1'b0;
      flag1 <= 1'b0;
    end else begin
      flag0 <= set0 | (flag0 & ~clr0);
      flag1 <= set1 | (flag1 & ~clr1);
    end
  end

  // flag life cycle: set by a match, held, and dropped only by a written zero
  sequence s_sw_clear0;
    clr0 && !set0;
  endsequence
  sequence s_sw_clear1;
    clr1 && !set1;
  endsequence
  a_flag_sets: assert property (
    set0 |=> flag0)
    else $error("alarm 0 flag not set");
  a_flag1_sets: assert property (
    set1 |=> flag1)
    else $error("alarm 1 flag not set");
  a_flag_holds: assert property (
    flag1 && !clr1 |=> flag1)
    else $error("alarm 1 flag lost");
  a_flag0_holds: assert property (
    flag0 && !clr0 |=> flag0)
    else $error("alarm 0 flag lost");
  a_clear0_works: assert property (
    s_sw_clear0 |=> !flag0)
    else $error("alarm 0 flag not cleared");
  a_clear1_works: assert property (
    s_sw_clear1 |=> !flag1)
    else $error("alarm 1 flag not cleared");
  a_write_one: assert property (
    !flag0 && !set0 |=> !flag0)
    else $error("flag set without match");
  a_one_ignored: assert property (
    !flag1 && !set1 |=> !flag1)
    else $error("alarm 1 flag set without match");
  a_enable_gate: assert property (
    !control[EN0_BIT] && !flag0 |=> !flag0)
    else $error("disabled alarm fired");
  a_enable1_gate: assert property (
    !control[EN1_BIT] && !flag1 |=> !flag1)
    else $error("disabled alarm 1 fired");
  a_tick_only: assert property (
    !i_tick && !flag1 |=> !flag1)
    else $error("set off tick");
  a_tick0_only: assert property (
    !i_tick && !flag0 |=> !flag0)
    else $error("alarm 0 set off tick");
  a_no_hsec0: assert property (
    sel0 == SEL_HSEC && !flag0 |=> !flag0)
    else $error("alarm 0 hundredths matched");

  // read mux; format bit mirrored live, flag overlaid on weekday
  always_comb begin
    unique case (i_req.addr)
      OFS_A0_SEC: next_rdata = a0_sec;
      OFS_A0_MIN: next_rdata = a0_min;
      OFS_A0_HOUR: next_rdata = {1'b0, i_format_12h, a0_hour[5:0]};
      OFS_A0_WEEKDAY_VALUE: next_rdata = {a0_wk[7:4], flag0, a0_wk[2:0]};
      OFS_A0_DATE: next_rdata = a0_date;
      OFS_A0_MONTH: next_rdata = a0_month;
      OFS_A1_HSEC: next_rdata = a1_hsec;
      OFS_A1_SEC: next_rdata = a1_sec;
      OFS_A1_MIN: next_rdata = a1_min;
      OFS_A1_HOUR: next_rdata = {1'b0, i_format_12h, a1_hour[5:0]};
      OFS_A1_WEEKDAY_VALUE: next_rdata = {a1_wk[7:4], flag1, a1_wk[2:0]};
      OFS_A1_DATE: next_rdata = a1_date;
      OFS_CONTROL: next_rdata = control;
      default: next_rdata = RST_ZERO;
    endcase
  end

  // registered read data, updated on a read strobe
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata <= RST_ZERO;
    end else if (i_req.rd) begin
      rdata <= next_rdata;
    end
  end

  // reads return the live format mirror and the live flag
  sequence s_rd_hour1;
    i_req.rd && i_req.addr == OFS_A1_HOUR;
  endsequence
  a_read_fmt: assert property (
    s_rd_hour1 |=> o_rdata[FORMAT_BIT] == $past(i_format_12h))
    else $error("format mirror wrong");
  a_read_flag: assert property (
    i_req.rd && i_req.addr == OFS_A0_WEEKDAY_VALUE |=> o_rdata[FLAG_BIT] == $past(flag0))
    else $error("flag not shown on read");

  // pin is pulled low while any flag stands, unless square wave mode owns it
  assign o_rdata = rdata;
  assign o_control = control;
  assign o_mfp_out = 1'b0;
  assign o_mfp_oe = (flag0 | flag1) & ~control[SQW_BIT];

  // pin pull follows the flags unless the square wave owns the pin
  sequence s_both_clear;
    (clr0 || !flag0) && (clr1 || !flag1) && !set0 && !set1;
  endsequence
  a_pin_low: assert property (
    (flag0 || flag1) && !control[SQW_BIT] |-> o_mfp_oe)
    else $error("pin not pulled");
  a_pin_follows: assert property (
    set0 && !control[SQW_BIT] && !(wr && i_req.addr == OFS_CONTROL) |=> o_mfp_oe)
    else $error("match did not reach pin");
  a_pin_release: assert property (
    s_both_clear |=> !o_mfp_oe)
    else $error("pin held after both flags cleared");
  a_pin_data: assert property (
    o_mfp_oe |-> !o_mfp_out)
    else $error("pin driven high");
  a_sqw_yields: assert property (
    control[SQW_BIT] |-> !o_mfp_oe)
    else $error("alarm pulls pin in square wave mode");
endmodule : dual_calendar_alarm_match
`default_nettype wire

// *** tb/host_model.sv ***
// host side serial controller model: issues one register access at a time
`timescale 1ns/1ps
`default_nettype none
module host_model import alarm_pkg::*; (
  // clock
  input wire logic i_clock,
  // register access
  output var reg_req_t o_req,
  input wire logic [7:0] i_rdata
);
  // idle lines show the inverse of the last value, never a stale copy
  initial o_req = '0;
  // write strobe held for exactly one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_clock);
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  // read data is registered at the strobe edge, taken one half cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clock);
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge i_clock);
    d = i_rdata;
    o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
  endtask : rd
endmodule : host_model
`default_nettype wire

// *** tb/test_dual_calendar_alarm_match.sv ***
// self-checking bench for the dual calendar alarm block
`timescale 1ns/1ps
`default_nettype none
module test_dual_calendar_alarm_match import alarm_pkg::*;;
  logic clock, rst_n, tk, fmt, mfp_out, mfp_oe;
  logic [7:0] rdata, control;
  reg_req_t req;
  time_now_t now;
  int n_mismatch = 0;
  int checked = 0;
  logic [7:0] masks [12] = '{8'h7f, 8'h7f, 8'h7f, 8'h77, 8'h3f, 8'h1f,
                             8'hff, 8'h7f, 8'h7f, 8'h7f, 8'h77, 8'h3f};
  dual_calendar_alarm_match dut (.i_clock(clock), .i_rst_n(rst_n), .i_req(req),
    .o_rdata(rdata), .i_tick(tk), .i_now(now), .i_format_12h(fmt),
    .o_mfp_out(mfp_out), .o_mfp_oe(mfp_oe), .o_control(control));
  host_model host (.i_clock(clock), .o_req(req), .i_rdata(rdata));
  // 125 mhz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    check(v, exp);
  endtask : rdchk
  // counters update once per tick pulse
  task automatic tick(input time_now_t t);
    @(negedge clock);
    now = t;
    tk = 1'b1;
    @(negedge clock);
    tk = 1'b0;
  endtask : tick
  task automatic t_reset();
    for (int i = 0; i < 12; i++) begin
      rdchk(8'h0c + 8'(i), (i inside {3, 4, 5, 10, 11}) ? 8'h01 : 8'h00);
    end
    rdchk(8'h08, 8'h00);
    rdchk(8'h20, 8'h00);
  endtask : t_reset
  // all ones written: unused bits read zero, flag cannot be set by a write
  task automatic t_masks();
    fmt = 1'b1;
    host.wr(8'h20, 8'hff);
    for (int i = 0; i < 12; i++) begin
      host.wr(8'h0c + 8'(i), 8'hff);
      rdchk(8'h0c + 8'(i), masks[i]);
    end
    fmt = 1'b0;
    rdchk(8'h0e, 8'h3f);
    rdchk(8'h20, 8'h00);
  endtask : t_masks
  task automatic t_sec_flag();
    host.wr(8'h08, 8'h00);
    host.wr(8'h0c, 8'h42);
    host.wr(8'h0f, 8'h01);
    tick('{8'h00, 7'h42, 7'h00, 7'h00, 3'h1, 6'h01, 5'h01});
    rdchk(8'h0f, 8'h01);
    host.wr(8'h08, 8'h10);
    tick('{8'h00, 7'h41, 7'h00, 7'h00, 3'h1, 6'h01, 5'h01});
    rdchk(8'h0f, 8'h01);
    tick('{8'h00, 7'h42, 7'h00, 7'h00, 3'h1, 6'h01, 5'h01});
    rdchk(8'h0f, 8'h09);
    check({7'h00, mfp_oe}, 8'h01);
    check({7'h00, mfp_out}, 8'h00);
    check(control, 8'h10);
    host.wr(8'h08, 8'h50);
    check({7'h00, mfp_oe}, 8'h00);
    host.wr(8'h08, 8'h10);
    check({7'h00, mfp_oe}, 8'h01);
    host.wr(8'h0f, 8'h09);
    rdchk(8'h0f, 8'h09);
    host.wr(8'h0f, 8'h01);
    rdchk(8'h0f, 8'h01);
    check({7'h00, mfp_oe}, 8'h00);
  endtask : t_sec_flag
  // 12-hour compare needs the afternoon bit to agree
  task automatic t_hour12();
    fmt = 1'b1;
    host.wr(8'h0e, 8'h31);
    host.wr(8'h0f, 8'h21);
    tick('{8'h00, 7'h00, 7'h00, 7'h51, 3'h1, 6'h01, 5'h01});
    rdchk(8'h0f, 8'h21);
    tick('{8'h00, 7'h00, 7'h00, 7'h71, 3'h1, 6'h01, 5'h01});
    rdchk(8'h0f, 8'h29);
    rdchk(8'h0e, 8'h71);
    fmt = 1'b0;
    host.wr(8'h0f, 8'h01);
  endtask : t_hour12
  // every select code on alarm 1; month and hundredths differ from the match values
  task automatic t_selects();
    logic [7:0] a1 [6] = '{8'h00, 8'h10, 8'h20, 8'h08, 8'h03, 8'h15};
    for (int i = 0; i < 6; i++) host.wr(8'h12 + 8'(i), a1[i]);
    host.wr(8'h08, 8'h30);
    host.wr(8'h0f, 8'h51);
    for (int s = 0; s < 8; s++) begin
      host.wr(8'h16, {1'b0, 3'(s), 4'h3});
      tick('{8'h99, 7'h10, 7'h21, 7'h09, 3'h4, 6'h16, 5'h05});
      rdchk(8'h16, {1'b0, 3'(s), (s == 0), 3'h3});
      host.wr(8'h16, {1'b0, 3'(s), 4'h3});
      tick('{8'h99, 7'h10, 7'h20, 7'h08, 3'h3, 6'h15, 5'h05});
      rdchk(8'h16, {1'b0, 3'(s), !(s inside {5, 6}), 3'h3});
    end
    rdchk(8'h0f, 8'h51);
    host.wr(8'h16, 8'h53);
    tick('{8'h99, 7'h10, 7'h20, 7'h08, 3'h3, 6'h15, 5'h05});
    rdchk(8'h16, 8'h53);
    tick('{8'h37, 7'h00, 7'h00, 7'h00, 3'h1, 6'h01, 5'h01});
    host.wr(8'h12, 8'h37);
    rdchk(8'h16, 8'h53);
    tick('{8'h37, 7'h00, 7'h00, 7'h00, 3'h1, 6'h01, 5'h01});
    rdchk(8'h16, 8'h5b);
    rdchk(8'h0f, 8'h51);
  endtask : t_selects
  // alarm 0 full match needs the month too; code 110 never fires
  task automatic t_month0();
    host.wr(8'h0c, 8'h30);
    host.wr(8'h0d, 8'h45);
    host.wr(8'h0e, 8'h12);
    host.wr(8'h10, 8'h28);
    host.wr(8'h11, 8'h11);
    host.wr(8'h0f, 8'h75);
    tick('{8'h00, 7'h30, 7'h45, 7'h12, 3'h5, 6'h28, 5'h10});
    rdchk(8'h0f, 8'h75);
    tick('{8'h00, 7'h30, 7'h45, 7'h12, 3'h5, 6'h28, 5'h11});
    rdchk(8'h0f, 8'h7d);
    host.wr(8'h0f, 8'h65);
    tick('{8'h00, 7'h30, 7'h45, 7'h12, 3'h5, 6'h28, 5'h11});
    rdchk(8'h0f, 8'h65);
  endtask : t_month0
  // reset in mid-run drops flags and pin and restores every value
  task automatic t_midreset();
    check({7'h00, mfp_oe}, 8'h01);
    @(negedge clock);
    rst_n = 1'b0;
    #1;
    check({7'h00, mfp_oe}, 8'h00);
    check(control, 8'h00);
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
  endtask : t_midreset
  task automatic wrap_up();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #400000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    tk = 1'b0;
    fmt = 1'b0;
    now = '0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_masks();
    t_sec_flag();
    t_hour12();
    t_selects();
    t_month0();
    t_midreset();
    wrap_up();
  end
endmodule : test_dual_calendar_alarm_match
`default_nettype wire
